//--- include/hsc_defs.vh
// constants for the host serial control port of a line interface unit
// assumes: included by bare name from rtl files; definitions only
`ifndef HSC_DEFS_VH
`define HSC_DEFS_VH

// command register addresses
`define HSC_ADDR_CHAN_CTRL   3'h0
`define HSC_ADDR_INT_STATUS  3'h1
`define HSC_ADDR_ALARM       3'h2
`define HSC_ADDR_SCRATCH     3'h3

// channel control register fields
`define HSC_CTRL_INT_EN      0
`define HSC_CTRL_LOOP_LO     1
`define HSC_CTRL_LOOP_HI     2
`define HSC_CTRL_MUTE        3
`define HSC_CTRL_RX_ON       4
`define HSC_CTRL_MON         5
`define HSC_CTRL_RXINV       6
`define HSC_CTRL_TXINV       7

// interrupt status and alarm fields
`define HSC_BIT_LOS          0
`define HSC_BIT_LOL          1

// register defaults
`define HSC_CTRL_RESET       8'h10
`define HSC_STATUS_RESET     8'h00
`define HSC_SCRATCH_RESET    8'h00

// loopback mode codes, {remote, local}
`define HSC_LOOP_NORMAL      2'h0
`define HSC_LOOP_ANALOG      2'h1
`define HSC_LOOP_REMOTE      2'h2
`define HSC_LOOP_DIGITAL     2'h3

// synchroniser bus width
`define HSC_SYNC_W           14

`endif

//--- rtl/sync2.v
// two-flop synchroniser for a vector of independent levels
// assumes: each bit is a slow level or a clock far slower than clock
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
    parameter W = 1
) (
    input  wire         clock,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);
    reg [W-1:0] meta_r;   // first stage, read only by second

    // two stages, no reset so no constant fights the sampling
    always @(posedge clock) begin
        meta_r   <= async_in;
        sync_out <= meta_r;
    end
endmodule // sync2
`default_nettype wire

//--- rtl/line_path.v
// loopback mode latch and recovered-rail muting on line clock edges
// assumes: all inputs already synchronised to clock
`timescale 1ns/100ps
`default_nettype none
`include "hsc_defs.vh"
module line_path (
    input  wire       clock,
    input  wire       resetn,
    input  wire       line_clock_s,
    input  wire [1:0] loop_req,
    input  wire       mute_en,
    input  wire       los_s,
    input  wire       pos_s,
    input  wire       neg_s,
    output reg  [1:0] loop_mode,
    output reg        recovered_pos_rail,
    output reg        recovered_neg_rail
);
    reg line_clock_d;          // previous line clock sample
    wire line_edge;            // one-cycle pulse per line clock rise

    assign line_edge = line_clock_s & ~line_clock_d;

    // apply mode and rails only on a line clock boundary
    always @(posedge clock) begin
        if (!resetn) begin
            line_clock_d       <= 1'b1; // no false edge after reset
            loop_mode          <= `HSC_LOOP_NORMAL;
            recovered_pos_rail <= 1'b0;
            recovered_neg_rail <= 1'b0;
        end else begin
            line_clock_d <= line_clock_s;
            if (line_edge) begin
                loop_mode <= loop_req;
                // muted rails go low while signal is lost
                recovered_pos_rail <= pos_s & ~(mute_en & los_s);
                recovered_neg_rail <= neg_s & ~(mute_en & los_s);
            end
        end
    end
endmodule // line_path
`default_nettype wire

//--- rtl/host_serial_control_port.v
// control port: serial host interface, command registers, interrupt,
// loopback selection and hardware-mode reuse of the serial pins
// assumes: all pins but resetn asynchronous to clock; serial clock well below clock/4
//
// Summary of operation
// - hardware mode: loop pins pick normal/local/remote/digital
// - host mode ignores both loop select pins
// - transfers accepted only while chip select low
// - serial input sampled on serial clock rise
// - read data changes on serial clock fall
// - read shifts out the addressed command register
// - serial output driven only during read data
// - register reset low restores all defaults
// - host mode: interrupt pin falls when pending
// - interrupt enable zero keeps interrupt pin high
// - hardware mode: serial pins become discrete controls
// - config pin high host mode, low hardware
// - hardware mute input forces rails low on loss
`timescale 1ns/100ps
`default_nettype none
`include "hsc_defs.vh"
module host_serial_control_port #(
    parameter ADDR_W = 3,          // address bits in a frame
    parameter DATA_W = 8           // data bits in a frame
) (
    input  wire       clock,
    input  wire       resetn,
    input  wire       config_source_select,
    input  wire       reg_reset_n,
    input  wire       cs_pin_n,
    input  wire       sclk_pin,
    input  wire       serial_in,
    input  wire       sout_pin,
    output reg        serial_out,
    output reg        serial_out_oe,
    input  wire       int_pin_in,
    output reg        int_pin_out,
    output reg        int_pin_oe,
    input  wire       local_loop_select,
    input  wire       remote_loop_select,
    input  wire       line_clock,
    input  wire       loss_of_signal,
    input  wire       loss_of_lock,
    input  wire       rx_pos_data,
    input  wire       rx_neg_data,
    output reg        host_mode,
    output reg        rx_clock_invert,
    output reg        tx_clock_invert,
    output reg        receiver_on,
    output reg        rx_monitor_mode,
    output wire [1:0] loop_mode,
    output wire       recovered_pos_rail,
    output wire       recovered_neg_rail
);
    // engine states
    localparam ST_CMD   = 2'h0;
    localparam ST_RDATA = 2'h1;
    localparam ST_WDATA = 2'h2;
    localparam ST_DONE  = 2'h3;
    localparam CNT_W    = 5;
    localparam [CNT_W-1:0] CMD_LAST  = ADDR_W[CNT_W-1:0];
    localparam [CNT_W-1:0] DATA_LAST = DATA_W[CNT_W-1:0] - 1'b1;

    // rising edge of a sampled level
    function rise_of;
        input cur;
        input prev;
        begin
            rise_of = cur & ~prev;
        end
    endfunction

    // synchronised pins
    wire [`HSC_SYNC_W-1:0] sync_q;
    wire cfg_s;                    // config source level
    wire cs_s;                     // chip select, active low
    wire sclk_s;                   // serial clock
    wire sin_s;                    // serial input
    wire sout_s;                   // serial output pin as input
    wire int_in_s;                 // interrupt pin as input
    wire lloop_s;                  // local loop select
    wire rloop_s;                  // remote loop select
    wire rrst_s;                   // register reset, active low
    wire lclk_s;                   // line clock
    wire los_s;                    // loss of signal
    wire lol_s;                    // loss of lock
    wire pos_s;                    // positive rail data
    wire neg_s;                    // negative rail data

    sync2 #(
        .W (`HSC_SYNC_W)
    ) u_sync (
        .clock    (clock),
        .async_in ({config_source_select, cs_pin_n, sclk_pin, serial_in,
                    sout_pin, int_pin_in, local_loop_select,
                    remote_loop_select, reg_reset_n, line_clock,
                    loss_of_signal, loss_of_lock, rx_pos_data, rx_neg_data}),
        .sync_out (sync_q)
    );

    assign {cfg_s, cs_s, sclk_s, sin_s, sout_s, int_in_s, lloop_s, rloop_s,
            rrst_s, lclk_s, los_s, lol_s, pos_s, neg_s} = sync_q;

    // engine and register state
    reg              sclk_d;       // previous serial clock
    reg              los_d;        // previous loss of signal
    reg              lol_d;        // previous loss of lock
    reg  [1:0]       state_r;      // engine state
    reg  [CNT_W-1:0] cnt_r;        // bit counter in field
    reg  [ADDR_W:0]  cmd_sr;       // read flag and address
    reg  [ADDR_W-1:0] addr_r;      // latched write address
    reg  [DATA_W-1:0] data_sr;     // data shifter
    reg  [DATA_W-1:0] ctrl_r;      // channel control register
    reg  [DATA_W-1:0] istat_r;     // sticky interrupt status
    reg  [DATA_W-1:0] scratch_r;   // free read/write register

    // combinational helpers
    wire             sclk_rise;
    wire             sclk_fall;
    wire             active;
    wire             reg_rst;
    wire [ADDR_W:0]  cmd_full;     // command with the bit now arriving
    wire [ADDR_W-1:0] cmd_addr;
    wire [DATA_W-1:0] wr_full;     // write data with final bit
    wire             rd_clear;     // status read clears the status
    wire             wr_strobe;
    reg  [DATA_W-1:0] rd_data;
    reg  [DATA_W-1:0] istat_set;
    reg  [1:0]       loop_req;
    reg              mute_en;

    assign sclk_rise = rise_of(sclk_s, sclk_d);
    assign sclk_fall = rise_of(sclk_d, sclk_s);
    assign active    = cfg_s & ~cs_s;
    assign reg_rst   = ~resetn | ~rrst_s;
    assign cmd_full  = {cmd_sr[ADDR_W-1:0], sin_s};
    assign cmd_addr  = cmd_full[ADDR_W-1:0];
    assign wr_full   = {data_sr[DATA_W-2:0], sin_s};
    assign rd_clear  = active & sclk_rise & (state_r == ST_CMD) &
                       (cnt_r == CMD_LAST) & cmd_full[ADDR_W] &
                       (cmd_addr == `HSC_ADDR_INT_STATUS);
    assign wr_strobe = active & sclk_rise & (state_r == ST_WDATA) &
                       (cnt_r == DATA_LAST);

    // read mux over the command registers
    always @* begin
        case (cmd_addr)
            `HSC_ADDR_CHAN_CTRL:  rd_data = ctrl_r;
            `HSC_ADDR_INT_STATUS: rd_data = istat_r;
            `HSC_ADDR_ALARM: begin
                rd_data = {DATA_W{1'b0}};
                rd_data[`HSC_BIT_LOS] = los_s;
                rd_data[`HSC_BIT_LOL] = lol_s;
            end
            `HSC_ADDR_SCRATCH:    rd_data = scratch_r;
            default:              rd_data = {DATA_W{1'b0}};
        endcase
    end

    // alarm rises that set sticky status bits
    always @* begin
        istat_set = {DATA_W{1'b0}};
        istat_set[`HSC_BIT_LOS] = rise_of(los_s, los_d);
        istat_set[`HSC_BIT_LOL] = rise_of(lol_s, lol_d);
    end

    // loop request and mute source by configuration mode
    always @* begin
        if (cfg_s) begin
            loop_req = {ctrl_r[`HSC_CTRL_LOOP_HI], ctrl_r[`HSC_CTRL_LOOP_LO]};
            mute_en  = ctrl_r[`HSC_CTRL_MUTE];
        end else begin
            loop_req = {rloop_s, lloop_s};
            mute_en  = int_in_s;
        end
    end

    // serial frame engine: read flag, address, then data, msb first
    always @(posedge clock) begin
        if (!resetn) begin
            sclk_d        <= 1'b0;
            state_r       <= ST_CMD;
            cnt_r         <= {CNT_W{1'b0}};
            cmd_sr        <= {(ADDR_W+1){1'b0}};
            addr_r        <= {ADDR_W{1'b0}};
            data_sr       <= {DATA_W{1'b0}};
            serial_out    <= 1'b0;
            serial_out_oe <= 1'b0;
        end else begin
            sclk_d <= sclk_s;
            if (!active) begin
                // chip select high ends any frame
                state_r       <= ST_CMD;
                cnt_r         <= {CNT_W{1'b0}};
                serial_out_oe <= 1'b0;
            end else begin
                case (state_r)
                    ST_CMD: begin
                        if (sclk_rise) begin
                            cmd_sr <= cmd_full;
                            cnt_r  <= cnt_r + 1'b1;
                            if (cnt_r == CMD_LAST) begin
                                cnt_r  <= {CNT_W{1'b0}};
                                addr_r <= cmd_addr;
                                if (cmd_full[ADDR_W]) begin
                                    data_sr <= rd_data;
                                    state_r <= ST_RDATA;
                                end else begin
                                    state_r <= ST_WDATA;
                                end
                            end
                        end
                    end
                    ST_RDATA: begin
                        // present next bit on fall, count on rise
                        if (sclk_fall) begin
                            serial_out    <= data_sr[DATA_W-1];
                            data_sr       <= {data_sr[DATA_W-2:0], 1'b0};
                            serial_out_oe <= 1'b1;
                        end
                        if (sclk_rise) begin
                            cnt_r <= cnt_r + 1'b1;
                            if (cnt_r == DATA_LAST) begin
                                state_r <= ST_DONE;
                            end
                        end
                    end
                    ST_WDATA: begin
                        if (sclk_rise) begin
                            data_sr <= wr_full;
                            cnt_r   <= cnt_r + 1'b1;
                            if (cnt_r == DATA_LAST) begin
                                state_r <= ST_DONE;
                            end
                        end
                    end
                    ST_DONE: begin
                        // release the output after the last bit was taken
                        if (sclk_fall) begin
                            serial_out_oe <= 1'b0;
                        end
                    end
                    default: begin
                        state_r <= ST_CMD;
                    end
                endcase
            end
        end
    end

    // command registers; register reset pin clears them too
    always @(posedge clock) begin
        if (reg_rst) begin
            ctrl_r    <= `HSC_CTRL_RESET;
            istat_r   <= `HSC_STATUS_RESET;
            scratch_r <= `HSC_SCRATCH_RESET;
            los_d     <= 1'b0;
            lol_d     <= 1'b0;
        end else begin
            los_d <= los_s;
            lol_d <= lol_s;
            if (wr_strobe && addr_r == `HSC_ADDR_CHAN_CTRL) begin
                ctrl_r <= wr_full;
            end
            if (wr_strobe && addr_r == `HSC_ADDR_SCRATCH) begin
                scratch_r <= wr_full;
            end
            // new event wins over clear-on-read
            if (rd_clear) begin
                istat_r <= istat_set;
            end else begin
                istat_r <= istat_r | istat_set;
            end
        end
    end

    // pin functions and interrupt output by mode
    always @(posedge clock) begin
        if (!resetn) begin
            host_mode       <= 1'b0;
            int_pin_out     <= 1'b1;
            int_pin_oe      <= 1'b0;
            rx_clock_invert <= 1'b0;
            tx_clock_invert <= 1'b0;
            receiver_on     <= 1'b0;
            rx_monitor_mode <= 1'b0;
        end else begin
            host_mode <= cfg_s;
            if (cfg_s) begin
                // low while enabled and anything pending
                int_pin_out <= ~(ctrl_r[`HSC_CTRL_INT_EN] & (|istat_r));
                int_pin_oe  <= 1'b1;
                rx_clock_invert <= ctrl_r[`HSC_CTRL_RXINV];
                tx_clock_invert <= ctrl_r[`HSC_CTRL_TXINV];
                receiver_on     <= ctrl_r[`HSC_CTRL_RX_ON];
                rx_monitor_mode <= ctrl_r[`HSC_CTRL_MON];
            end else begin
                // pin is the mute input here, never driven
                int_pin_out     <= 1'b1;
                int_pin_oe      <= 1'b0;
                rx_clock_invert <= cs_s;
                tx_clock_invert <= sclk_s;
                receiver_on     <= sin_s;
                rx_monitor_mode <= sout_s;
            end
        end
    end

    // loop mode and rails on line clock edges
    line_path u_line (
        .clock              (clock),
        .resetn             (resetn),
        .line_clock_s       (lclk_s),
        .loop_req           (loop_req),
        .mute_en            (mute_en & ~cfg_s),
        .los_s              (los_s),
        .pos_s              (pos_s),
        .neg_s              (neg_s),
        .loop_mode          (loop_mode),
        .recovered_pos_rail (recovered_pos_rail),
        .recovered_neg_rail (recovered_neg_rail)
    );
endmodule // host_serial_control_port
`default_nettype wire

//--- dv/hsc_checker_sva.sv
// checker for the serial control port, bound to its top module
// assumes: one clock domain, resetn synchronous and active low
`timescale 1ns/100ps
`default_nettype none
module hsc_checker (
    input wire logic       clock,
    input wire logic       resetn,
    input wire logic       cs_pin_n,
    input wire logic       sclk_pin,
    input wire logic       serial_in,
    input wire logic       sout_pin,
    input wire logic       serial_out,
    input wire logic       serial_out_oe,
    input wire logic       int_pin_in,
    input wire logic       local_loop_select,
    input wire logic       remote_loop_select,
    input wire logic       line_clock,
    input wire logic       loss_of_signal,
    input wire logic       host_mode,
    input wire logic       rx_clock_invert,
    input wire logic       tx_clock_invert,
    input wire logic       receiver_on,
    input wire logic       rx_monitor_mode,
    input wire logic [1:0] loop_mode,
    input wire logic       recovered_pos_rail,
    input wire logic       recovered_neg_rail
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    logic [4:0] mute_cnt_r; // cycles the mute condition has held
    // count hardware-mode mute cycles, saturating
    always @(posedge clock) begin
        if (!resetn || host_mode || !int_pin_in || !loss_of_signal) begin
            mute_cnt_r <= 5'h00;
        end else if (mute_cnt_r != 5'h1f) begin
            mute_cnt_r <= mute_cnt_r + 5'h01;
        end
    end
    sequence s_hw_loop; (!host_mode && $stable({remote_loop_select, local_loop_select}))[*8];
    endsequence
    property p_oe_cs_high; cs_pin_n[*6] |-> !serial_out_oe; endproperty
    a_oe_cs_high: assert property (p_oe_cs_high) else $error("output driven, select high");
    property p_out_on_fall; $changed(serial_out) |-> !sclk_pin && !$past(sclk_pin, 2); endproperty
    a_out_on_fall: assert property (p_out_on_fall) else $error("output moved off a fall");
    property p_oe_rise; $rose(serial_out_oe) |-> host_mode && !cs_pin_n && !sclk_pin; endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("output enabled outside a read");
    property p_hw_loop;
        s_hw_loop ##1 $rose(line_clock) |-> ##4
            loop_mode == $past({remote_loop_select, local_loop_select}, 4);
    endproperty
    a_hw_loop: assert property (p_hw_loop) else $error("loop decode wrong");
    property p_host_ignore;
        host_mode && $changed({remote_loop_select, local_loop_select}) |-> ##1 $stable(loop_mode)[*6];
    endproperty
    a_host_ignore: assert property (p_host_ignore) else $error("host mode used loop pins");
    property p_hw_pins;
        (!host_mode && $stable({cs_pin_n, sclk_pin, serial_in, sout_pin}))[*6] |->
            {rx_clock_invert, tx_clock_invert, receiver_on, rx_monitor_mode}
            == {cs_pin_n, sclk_pin, serial_in, sout_pin};
    endproperty
    a_hw_pins: assert property (p_hw_pins) else $error("pin reuse wrong");
    property p_mute; mute_cnt_r >= 5'h10 |-> !recovered_pos_rail && !recovered_neg_rail; endproperty
    a_mute: assert property (p_mute) else $error("rails not muted");
    property p_loop_edge; $changed(loop_mode) |-> $past(line_clock, 2) && $past(line_clock, 3);
    endproperty
    a_loop_edge: assert property (p_loop_edge) else $error("loop changed off line edge");
    c_read: cover property ($rose(serial_out_oe));
    c_digital: cover property (!host_mode && loop_mode == 2'h3);
    c_mute: cover property (mute_cnt_r == 5'h1f);
endmodule // hsc_checker
bind host_serial_control_port hsc_checker i_chk (
    .clock(clock), .resetn(resetn), .cs_pin_n(cs_pin_n), .sclk_pin(sclk_pin),
    .serial_in(serial_in), .sout_pin(sout_pin), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .int_pin_in(int_pin_in), .line_clock(line_clock),
    .local_loop_select(local_loop_select), .remote_loop_select(remote_loop_select),
    .loss_of_signal(loss_of_signal), .host_mode(host_mode), .receiver_on(receiver_on),
    .rx_clock_invert(rx_clock_invert), .tx_clock_invert(tx_clock_invert),
    .rx_monitor_mode(rx_monitor_mode), .loop_mode(loop_mode),
    .recovered_pos_rail(recovered_pos_rail), .recovered_neg_rail(recovered_neg_rail)
);
`default_nettype wire

//--- dv/host_model.sv
// host controller model driving the serial port pins
// assumes: pins change 1 ns after a rising edge of the bench clock
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input  wire logic clock,
    input  wire logic sout_line,
    output logic      cs_pin_n,
    output logic      sclk_pin,
    output logic      serial_in
);
    localparam int PH = 8; // clocks per serial clock phase
    // idle: deselected, serial clock still and low
    initial begin
        cs_pin_n = 1'b1;
        sclk_pin = 1'b0;
        serial_in = 1'b0;
    end
    // wait n edges, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // one frame of nb bits; fewer than 12 cuts it short
    task automatic xfer(input logic rd, input logic [2:0] a, input logic [7:0] wd,
                        input int nb, output logic [7:0] q);
        logic [11:0] f;
        f = {rd, a, wd};
        q = 8'h00;
        cs_pin_n = 1'b0;
        tick(PH);
        for (int i = 0; i < nb; i++) begin
            serial_in = f[11-i];
            tick(PH);
            if (i > 3) q = {q[6:0], sout_line}; // data bit taken before the rise
            sclk_pin = 1'b1;
            tick(PH);
            sclk_pin = 1'b0;
        end
        tick(PH);
        cs_pin_n = 1'b1;
        serial_in = 1'b0; // released input sits at its pull-down
        tick(PH);
    endtask
    // hardware mode: pins as plain levels
    task automatic pins(input logic c, input logic s, input logic d);
        cs_pin_n = c;
        sclk_pin = s;
        serial_in = d;
    endtask
endmodule // host_model
`default_nettype wire

//--- dv/tb_top.sv
// self-checking bench for the serial control port
// assumes: host_model and the bound checker are compiled before it
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clock, resetn, config_source_select, reg_reset_n, line_clock;
    logic loss_of_signal, loss_of_lock, local_loop_select, remote_loop_select;
    logic rx_pos_data, rx_neg_data, sout_ext, int_ext;
    logic cs_pin_n, sclk_pin, serial_in, serial_out, serial_out_oe, sout_pin;
    logic int_pin_in, int_pin_out, int_pin_oe, host_mode, receiver_on, rx_monitor_mode;
    logic rx_clock_invert, tx_clock_invert, recovered_pos_rail, recovered_neg_rail;
    logic [1:0] loop_mode;
    logic [7:0] v, q;
    int         err_count, n_tests;
    string      nm_q[$];
    logic [7:0] exp_q[$], got_q[$];
    // pin levels from all drivers
    assign sout_pin = serial_out_oe ? serial_out : sout_ext;
    assign int_pin_in = int_pin_oe ? int_pin_out : int_ext;
    host_model i_host (.clock(clock), .sout_line(sout_pin), .cs_pin_n(cs_pin_n),
        .sclk_pin(sclk_pin), .serial_in(serial_in));
    host_serial_control_port i_dut (.clock(clock), .resetn(resetn),
        .config_source_select(config_source_select), .reg_reset_n(reg_reset_n),
        .cs_pin_n(cs_pin_n), .sclk_pin(sclk_pin), .serial_in(serial_in),
        .sout_pin(sout_pin), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .int_pin_in(int_pin_in), .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe),
        .local_loop_select(local_loop_select), .remote_loop_select(remote_loop_select),
        .line_clock(line_clock), .loss_of_signal(loss_of_signal), .loss_of_lock(loss_of_lock),
        .rx_pos_data(rx_pos_data), .rx_neg_data(rx_neg_data), .host_mode(host_mode),
        .rx_clock_invert(rx_clock_invert), .tx_clock_invert(tx_clock_invert),
        .receiver_on(receiver_on), .rx_monitor_mode(rx_monitor_mode), .loop_mode(loop_mode),
        .recovered_pos_rail(recovered_pos_rail), .recovered_neg_rail(recovered_neg_rail));
    // bench clock, 50 ns
    always #25 clock = ~clock;
    // line clock, 400 ns, unrelated phase
    initial begin
        line_clock = 1'b0;
        #13;
        forever #200 line_clock = ~line_clock;
    end
    // undriven serial out line keeps changing in host mode
    always @(posedge clock) if (config_source_select) sout_ext <= #1 ~sout_ext;
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic note(input string nm, input logic [7:0] e);
        nm_q.push_back(nm);
        exp_q.push_back(e);
    endtask
    // note a result seen now beside its expectation
    task automatic obs(input string nm, input logic [7:0] e, input logic [7:0] g);
        note(nm, e);
        got_q.push_back(g);
    endtask
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] e);
        n_tests++;
        if (seen !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, seen);
        end
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        note("read data", e);
        i_host.xfer(1'b1, a, 8'h00, 12, q);
        got_q.push_back(q);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        i_host.xfer(1'b0, a, d, 12, q);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // watcher: oldest note against each result
    initial forever begin
        wait (got_q.size() > 0);
        check(nm_q.pop_front(), got_q.pop_front(), exp_q.pop_front());
    end
    // watchdog
    initial begin
        #1000000;
        err_count++;
        results();
    end
    // main sequence
    initial begin
        {clock, resetn, reg_reset_n, config_source_select, int_ext} = 5'h07;
        {loss_of_signal, loss_of_lock, local_loop_select, remote_loop_select} = 4'h0;
        {rx_pos_data, rx_neg_data, sout_ext} = 3'h0;
        void'($urandom(30));
        tick(5);
        resetn = 1'b1;
        tick(8);
        obs("pins", 8'he8, {host_mode, int_pin_out, int_pin_oe, serial_out_oe,
            receiver_on, rx_monitor_mode, loop_mode});
        rd(3'h0, 8'h10);
        rd(3'h5, 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            wr(3'h3, v);
            rd(3'h3, v);
        end
        wr(3'h6, 8'hff);
        rd(3'h6, 8'h00);
        wr(3'h2, 8'hff);
        rd(3'h2, 8'h00);
        i_host.xfer(1'b0, 3'h3, ~v, 8, q);
        rd(3'h3, v);
        $display("test frames done");
        wr(3'h0, 8'hf6);
        tick(8);
        remote_loop_select = 1'b1;
        tick(24);
        obs("ctrl pins", 8'hff, {rx_clock_invert, tx_clock_invert,
            receiver_on, rx_monitor_mode, 2'h3, loop_mode});
        remote_loop_select = 1'b0;
        wr(3'h0, 8'h10);
        loss_of_signal = 1'b1;
        tick(12);
        obs("int pin", 8'h01, {7'h0, int_pin_out});
        rd(3'h1, 8'h01);
        rd(3'h2, 8'h01);
        wr(3'h0, 8'h11);
        loss_of_lock = 1'b1;
        tick(12);
        obs("int pin", 8'h00, {7'h0, int_pin_out});
        rd(3'h1, 8'h02);
        obs("int pin", 8'h01, {7'h0, int_pin_out});
        {loss_of_signal, loss_of_lock} = 2'h0;
        $display("test interrupt done");
        reg_reset_n = 1'b0;
        tick(10);
        reg_reset_n = 1'b1;
        tick(4);
        rd(3'h0, 8'h10);
        rd(3'h3, 8'h00);
        $display("test register reset done");
        config_source_select = 1'b0;
        tick(8);
        for (int m = 0; m < 4; m++) begin
            {remote_loop_select, local_loop_select} = m[1:0];
            v = 8'($urandom);
            i_host.pins(v[0], v[1], v[2]);
            sout_ext = v[3];
            tick(24);
            obs("loop", {6'h0, m[1:0]}, {6'h0, loop_mode});
            obs("hw pins", {4'h0, v[0], v[1], v[2], v[3]}, {4'h0,
                rx_clock_invert, tx_clock_invert, receiver_on, rx_monitor_mode});
            obs("drive", 8'h00, {6'h0, int_pin_oe, serial_out_oe});
        end
        {remote_loop_select, local_loop_select, int_ext} = 3'h0;
        {rx_pos_data, rx_neg_data, loss_of_signal} = 3'h7;
        for (int k = 0; k < 3; k++) begin
            int_ext = (k == 1);
            loss_of_signal = (k < 2);
            tick(24);
            obs("rails", (k == 1) ? 8'h00 : 8'h03, {6'h0,
                recovered_pos_rail, recovered_neg_rail});
        end
        $display("test hardware mode done");
        wait (got_q.size() == 0);
        tick(2);
        results();
    end
endmodule // tb_top
`default_nettype wire
